// ### include/tcm_pkg.sv
// Constants and types shared by the timer clock and mode selection block.
// What this block does
// - Channel 0 codes: 000 clock/1, 001 clock/4, 100-111 pins A to D.
// - Channel 1: /4, /16, /64, pins A, B, /256, channel 2 overflow.
// - Channel 1 in phase counting ignores its clock-select field.
// - Channel 2: /1, /4, 011 /64, pins A to C, 111 /1024.
// - Channel 2 in phase counting ignores its clock-select field.
// - Channels 3 and 4: /1 to /1024 for 000-101, pins A and B.
// - One 8-bit read/write mode register for each of five channels.
// - Mode bits 7 and 6 read as 1; software writes 1.
// - Mode bit 5 pairs register B with register D for buffering.
// - Register D as buffer makes no capture or compare events.
// - Mode bit 4 pairs register A with register C for buffering.
// - Register C as buffer makes no capture or compare events.
// - Channels 1 and 2: mode bit 5 reads 0, writes ignored.
// - Channels 1 and 2: mode bit 4 reads 0, writes ignored.
// - Mode bits 3 to 0 are a read/write mode field, reset 0.
// - Mode field decodes normal, PWM, phase, reset-sync and complementary.
// - Phase counting only on channels 1, 2; PWM 2 not on 3, 4.
// - Channel 3 in reset-sync or complementary makes channel 4 follow it.
package tcm_pkg;
   localparam int NUM_CH = 5;
   localparam int NUM_PINS = 4;
   localparam int ADDR_W = 4;
   localparam int PRE_W = 10;
   // Register index: control at 2*ch, mode at 2*ch+1.
   localparam logic [ADDR_W-1:0] CTRL_BASE = 4'h0;
   localparam logic [ADDR_W-1:0] MODE_BASE = 4'h1;
   localparam logic [ADDR_W-1:0] LAST_IDX = 4'h9;
   // Control register fields.
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 3;
   localparam int EDGE_LSB = 3;
   localparam int EDGE_W = 2;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   // Mode register fields.
   localparam int MD_LSB = 0;
   localparam int MD_W = 4;
   localparam int BFA_BIT = 4;
   localparam int BFB_BIT = 5;
   localparam int MODE_ST_W = 6;
   localparam logic [1:0] MODE_RSV = 2'h3;
   localparam logic [MODE_ST_W-1:0] MODE_RST = 6'h00;
   // Prescaler tap bit for each division ratio.
   localparam int TAP_DIV4 = 1;
   localparam int TAP_DIV16 = 3;
   localparam int TAP_DIV64 = 5;
   localparam int TAP_DIV256 = 7;
   localparam int TAP_DIV1024 = 9;
   localparam logic [EDGE_W-1:0] EDGE_RISE = 2'h0;
   localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h1;

   typedef enum logic [3:0] {
      MD_NORMAL = 4'b0000,
      MD_PWM1 = 4'b0010,
      MD_PWM2 = 4'b0011,
      MD_PHASE1 = 4'b0100,
      MD_PHASE2 = 4'b0101,
      MD_PHASE3 = 4'b0110,
      MD_PHASE4 = 4'b0111,
      MD_RSYNC = 4'b1000,
      MD_COMP1 = 4'b1101,
      MD_COMP2 = 4'b1110,
      MD_COMP3 = 4'b1111
   } tcm_mode_t;

   typedef enum logic [3:0] {
      SRC_DIV1 = 4'h0,
      SRC_DIV4 = 4'h1,
      SRC_DIV16 = 4'h2,
      SRC_DIV64 = 4'h3,
      SRC_DIV256 = 4'h4,
      SRC_DIV1024 = 4'h5,
      SRC_PIN_A = 4'h6,
      SRC_PIN_B = 4'h7,
      SRC_PIN_C = 4'h8,
      SRC_PIN_D = 4'h9,
      SRC_CASCADE = 4'ha,
      SRC_NONE = 4'hb
   } tcm_src_t;
   localparam int NUM_SRC = 12;
endpackage : tcm_pkg

// ### src/tcm_pin_edge.sv
// Synchroniser and edge detector for one external clock pin.
`timescale 1ns/100ps
module tcm_pin_edge
   import tcm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pin and detected edges
   input wire logic pin_raw,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic rise;
      logic fall;
   } tcm_pe_state_t;

   tcm_pe_state_t st_q;
   tcm_pe_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_raw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.rise = st_q.s2 & ~st_q.s3;
      st_d.fall = ~st_q.s2 & st_q.s3;
      // The flops keep following the pin through reset, so a pin that is
      // already high at release shows no false edge.
      if (rst) begin
         st_d.rise = 1'b0;
         st_d.fall = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      st_q <= st_d;
   end

   assign rise = st_q.rise;
   assign fall = st_q.fall;
endmodule : tcm_pin_edge

// ### src/tcm_clk_mode_sel.sv
// Count-source selection and mode registers of a five-channel timer.
`timescale 1ns/100ps
module tcm_clk_mode_sel
   import tcm_pkg::*;
#(
   parameter int PRESC_W = PRE_W
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // External clock pins
   input wire logic ext_clk_pin_a,
   input wire logic ext_clk_pin_b,
   input wire logic ext_clk_pin_c,
   input wire logic ext_clk_pin_d,
   // Cascade pulse from the channel 2 counter, same clock
   input wire logic chan2_counter_ovf_unf,
   // Count enables, one per channel
   output logic [NUM_CH-1:0] count_tick,
   // Decoded mode per channel
   output logic [NUM_CH-1:0][MD_W-1:0] eff_mode,
   output logic [NUM_CH-1:0] phase_mode,
   output logic [NUM_CH-1:0] mode_prohibited,
   output logic [NUM_CH-1:0] buffer_pair_a_enable,
   output logic [NUM_CH-1:0] buffer_pair_b_enable,
   output logic [NUM_CH-1:0] gr_c_events_enable,
   output logic [NUM_CH-1:0] gr_d_events_enable
);
   typedef struct packed {
      logic [NUM_CH-1:0][CTRL_W-1:0] ctrl;
      logic [NUM_CH-1:0][MODE_ST_W-1:0] mode;
      logic [PRESC_W-1:0] pre;
      logic [7:0] rdata;
      logic [NUM_CH-1:0] tick;
      logic [NUM_CH-1:0][MD_W-1:0] eff;
      logic [NUM_CH-1:0] phase;
      logic [NUM_CH-1:0] bad;
      logic [NUM_CH-1:0] bfa;
      logic [NUM_CH-1:0] bfb;
      logic [NUM_CH-1:0] c_en;
      logic [NUM_CH-1:0] d_en;
   } tcm_state_t;

   tcm_state_t st_q;
   tcm_state_t st_d;

   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_rise;
   logic [NUM_PINS-1:0] pin_fall;

   assign pin_raw = {ext_clk_pin_d, ext_clk_pin_c,
                     ext_clk_pin_b, ext_clk_pin_a};

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
         tcm_pin_edge u_edge (
            .clk_sys(clk_sys),
            .rst(rst),
            .pin_raw(pin_raw[gp]),
            .rise(pin_rise[gp]),
            .fall(pin_fall[gp])
         );
      end
   endgenerate

   // Channels 1 and 2 have no registers C and D.
   function automatic logic no_cd(input int ch);
      return (ch == 1) || (ch == 2);
   endfunction : no_cd

   function automatic logic is_phase(input logic [MD_W-1:0] md);
      return (md == MD_PHASE1) || (md == MD_PHASE2) ||
             (md == MD_PHASE3) || (md == MD_PHASE4);
   endfunction : is_phase

   function automatic logic is_sync_comp(input logic [MD_W-1:0] md);
      return (md == MD_RSYNC) || (md == MD_COMP1) ||
             (md == MD_COMP2) || (md == MD_COMP3);
   endfunction : is_sync_comp

   function automatic logic is_legal(input logic [MD_W-1:0] md);
      return (md == MD_NORMAL) || (md == MD_PWM1) ||
             (md == MD_PWM2) || is_phase(md) || is_sync_comp(md);
   endfunction : is_legal

   function automatic logic allowed(input int ch,
                                    input logic [MD_W-1:0] md);
      logic ok;
      ok = is_legal(md);
      if (is_phase(md) && !no_cd(ch)) begin
         ok = 1'b0;
      end
      if ((md == MD_PWM2) && (ch >= 3)) begin
         ok = 1'b0;
      end
      if (is_sync_comp(md) && (ch != 3)) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : allowed

   // Maps a channel and its select code to a count source.
   function automatic tcm_src_t src_of(input int ch,
                                       input logic [SEL_W-1:0] sel);
      tcm_src_t s;
      s = SRC_NONE;
      case (ch)
         0: begin
            case (sel)
               3'b000: s = SRC_DIV1;
               3'b001: s = SRC_DIV4;
               3'b100: s = SRC_PIN_A;
               3'b101: s = SRC_PIN_B;
               3'b110: s = SRC_PIN_C;
               3'b111: s = SRC_PIN_D;
               default: s = SRC_NONE;
            endcase
         end
         1: begin
            case (sel)
               3'b001: s = SRC_DIV4;
               3'b010: s = SRC_DIV16;
               3'b011: s = SRC_DIV64;
               3'b100: s = SRC_PIN_A;
               3'b101: s = SRC_PIN_B;
               3'b110: s = SRC_DIV256;
               3'b111: s = SRC_CASCADE;
               default: s = SRC_NONE;
            endcase
         end
         2: begin
            case (sel)
               3'b000: s = SRC_DIV1;
               3'b001: s = SRC_DIV4;
               3'b011: s = SRC_DIV64;
               3'b100: s = SRC_PIN_A;
               3'b101: s = SRC_PIN_B;
               3'b110: s = SRC_PIN_C;
               3'b111: s = SRC_DIV1024;
               default: s = SRC_NONE;
            endcase
         end
         default: begin
            case (sel)
               3'b000: s = SRC_DIV1;
               3'b001: s = SRC_DIV4;
               3'b010: s = SRC_DIV16;
               3'b011: s = SRC_DIV64;
               3'b100: s = SRC_DIV256;
               3'b101: s = SRC_DIV1024;
               3'b110: s = SRC_PIN_A;
               default: s = SRC_PIN_B;
            endcase
         end
      endcase
      return s;
   endfunction : src_of

   // Read value of a mode register.
   function automatic logic [7:0] mode_view(input int ch,
                                            input logic [5:0] m);
      logic [7:0] v;
      v = {MODE_RSV, m};
      if (no_cd(ch)) begin
         v[BFB_BIT] = 1'b0;
         v[BFA_BIT] = 1'b0;
      end
      return v;
   endfunction : mode_view

   logic [PRESC_W-1:0] pre_nx;
   logic [NUM_SRC-1:0] src_rise;
   logic [NUM_SRC-1:0] src_fall;

   assign pre_nx = st_q.pre + {{(PRESC_W-1){1'b0}}, 1'b1};

   // Prescaler taps give one rise and one fall per period; divide by one
   // and the cascade pulse count once whatever the edge setting.
   always_comb begin
      src_rise = '0;
      src_fall = '0;
      src_rise[SRC_DIV1] = 1'b1;
      src_fall[SRC_DIV1] = 1'b1;
      src_rise[SRC_DIV4] = ~st_q.pre[TAP_DIV4] & pre_nx[TAP_DIV4];
      src_fall[SRC_DIV4] = st_q.pre[TAP_DIV4] & ~pre_nx[TAP_DIV4];
      src_rise[SRC_DIV16] = ~st_q.pre[TAP_DIV16] & pre_nx[TAP_DIV16];
      src_fall[SRC_DIV16] = st_q.pre[TAP_DIV16] & ~pre_nx[TAP_DIV16];
      src_rise[SRC_DIV64] = ~st_q.pre[TAP_DIV64] & pre_nx[TAP_DIV64];
      src_fall[SRC_DIV64] = st_q.pre[TAP_DIV64] & ~pre_nx[TAP_DIV64];
      src_rise[SRC_DIV256] = ~st_q.pre[TAP_DIV256] & pre_nx[TAP_DIV256];
      src_fall[SRC_DIV256] = st_q.pre[TAP_DIV256] & ~pre_nx[TAP_DIV256];
      src_rise[SRC_DIV1024] = ~st_q.pre[TAP_DIV1024] &
                              pre_nx[TAP_DIV1024];
      src_fall[SRC_DIV1024] = st_q.pre[TAP_DIV1024] &
                              ~pre_nx[TAP_DIV1024];
      src_rise[SRC_PIN_D:SRC_PIN_A] = pin_rise;
      src_fall[SRC_PIN_D:SRC_PIN_A] = pin_fall;
      // The cascade pulse comes from the same clock, so it skips the
      // synchroniser and ticks one cycle after the pulse.
      src_rise[SRC_CASCADE] = chan2_counter_ovf_unf;
      src_fall[SRC_CASCADE] = chan2_counter_ovf_unf;
   end

   always_comb begin
      logic [MD_W-1:0] md;
      logic [MD_W-1:0] md3;
      logic [EDGE_W-1:0] eg;
      logic [ADDR_W-1:0] idx;
      tcm_src_t src;
      logic hit;
      md = '0;
      md3 = st_q.mode[3][MD_LSB +: MD_W];
      eg = '0;
      idx = '0;
      src = SRC_NONE;
      hit = 1'b0;
      st_d = st_q;
      st_d.pre = pre_nx;

      // software only writes while stopped; no interlock here
      // A mode write lands at once even while a counter runs; keeping the
      // counter stopped is left to software.
      for (int ch = 0; ch < NUM_CH; ch++) begin
         idx = ADDR_W'(2 * ch);
         if (reg_wr && (reg_addr == (CTRL_BASE + idx))) begin
            st_d.ctrl[ch] = reg_wdata[CTRL_W-1:0];
         end
         if (reg_wr && (reg_addr == (MODE_BASE + idx))) begin
            // bits 7 and 6 are not stored
            st_d.mode[ch] = reg_wdata[MODE_ST_W-1:0];
            if (no_cd(ch)) begin
               st_d.mode[ch][BFB_BIT] = 1'b0;
               st_d.mode[ch][BFA_BIT] = 1'b0;
            end
         end
      end

      // Read data stands for the cycle after the strobe only.
      st_d.rdata = '0;
      if (reg_rd) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            idx = ADDR_W'(2 * ch);
            if (reg_addr == (CTRL_BASE + idx)) begin
               st_d.rdata = {3'h0, st_q.ctrl[ch]};
               hit = 1'b1;
            end
            if (reg_addr == (MODE_BASE + idx)) begin
               st_d.rdata = mode_view(ch, st_q.mode[ch]);
               hit = 1'b1;
            end
         end
         if (!hit || (reg_addr > LAST_IDX)) begin
            st_d.rdata = '0;
         end
      end

      for (int ch = 0; ch < NUM_CH; ch++) begin
         md = st_q.mode[ch][MD_LSB +: MD_W];
         // judge the channel's own code, so a channel 4 that
         // follows channel 3 is not flagged for the code it follows.
         st_d.bad[ch] = !allowed(ch, md);
         st_d.bfa[ch] = st_q.mode[ch][BFA_BIT];
         st_d.bfb[ch] = st_q.mode[ch][BFB_BIT];
         if ((ch == 4) && is_sync_comp(md3)) begin
            md = md3;
            st_d.bfa[ch] = st_q.mode[3][BFA_BIT];
            st_d.bfb[ch] = st_q.mode[3][BFB_BIT];
         end
         st_d.eff[ch] = md;
         st_d.phase[ch] = is_phase(md) && no_cd(ch);
         st_d.d_en[ch] = !no_cd(ch) && !st_d.bfb[ch];
         st_d.c_en[ch] = !no_cd(ch) && !st_d.bfa[ch];

         src = src_of(ch, st_q.ctrl[ch][SEL_LSB +: SEL_W]);
         eg = st_q.ctrl[ch][EDGE_LSB +: EDGE_W];
         // An unlisted select code picks no source, so the channel stands
         // still instead of counting some arbitrary clock.
         // edge selection
         if (src == SRC_NONE) begin
            st_d.tick[ch] = 1'b0;
         end else if (eg == EDGE_RISE) begin
            st_d.tick[ch] = src_rise[src];
         end else if (eg == EDGE_FALL) begin
            st_d.tick[ch] = src_fall[src];
         end else begin
            st_d.tick[ch] = src_rise[src] | src_fall[src];
         end
         if (st_d.phase[ch]) begin
            st_d.tick[ch] = 1'b0;
         end
      end
   end

   // Reset also restarts the prescaler, so every tap starts in phase
   // after a reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= '0;
         for (int ch = 0; ch < NUM_CH; ch++) begin
            st_q.ctrl[ch] <= CTRL_RST;
            st_q.mode[ch] <= MODE_RST;
         end
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign count_tick = st_q.tick;
   assign eff_mode = st_q.eff;
   assign phase_mode = st_q.phase;
   assign mode_prohibited = st_q.bad;
   assign buffer_pair_a_enable = st_q.bfa;
   assign buffer_pair_b_enable = st_q.bfb;
   assign gr_c_events_enable = st_q.c_en;
   assign gr_d_events_enable = st_q.d_en;
endmodule : tcm_clk_mode_sel

// ### test/tcm_pin_model.sv
// Far-side model: four external clock pins and the cascade pulse.
`timescale 1ns/100ps
module tcm_pin_model
(
   // Clock
   input wire logic clk_sys,
   // Pins and cascade pulse
   output logic ext_clk_pin_a,
   output logic ext_clk_pin_b,
   output logic ext_clk_pin_c,
   output logic ext_clk_pin_d,
   output logic chan2_counter_ovf_unf
);
   logic [8:0] cnt_q = 9'h000;
   logic ovf_q = 1'b0;
   // Pins move on the falling edge, half a cycle away from sampling.
   always @(negedge clk_sys) begin
      cnt_q <= cnt_q + 9'h001;
   end
   // The cascade is a same-clock pulse, here one every other cycle.
   always @(posedge clk_sys) begin
      ovf_q <= ~ovf_q;
   end
   // Periods of 8, 32, 128 and 512 cycles keep every source count distinct.
   assign ext_clk_pin_a = cnt_q[2];
   assign ext_clk_pin_b = cnt_q[4];
   assign ext_clk_pin_c = cnt_q[6];
   assign ext_clk_pin_d = cnt_q[8];
   assign chan2_counter_ovf_unf = ovf_q;
endmodule : tcm_pin_model

// ### test/tcm_clk_mode_sel_sva.sv
// Port-level checks for the clock and mode selection block.
`timescale 1ns/100ps
module tcm_clk_mode_sel_sva
   import tcm_pkg::*;
#(
   parameter int PRESC_W = PRE_W
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Outputs
   input wire logic [NUM_CH-1:0] count_tick,
   input wire logic [NUM_CH-1:0][MD_W-1:0] eff_mode,
   input wire logic [NUM_CH-1:0] phase_mode,
   input wire logic [NUM_CH-1:0] buffer_pair_a_enable,
   input wire logic [NUM_CH-1:0] buffer_pair_b_enable,
   input wire logic [NUM_CH-1:0] gr_c_events_enable,
   input wire logic [NUM_CH-1:0] gr_d_events_enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_ph1_held;
      phase_mode[1] [*3];
   endsequence
   sequence s_ph2_held;
      phase_mode[2] [*3];
   endsequence
   sequence s_mode0_wr;
      reg_wr && reg_addr == 4'h1;
   endsequence

   a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_mode_rsv_ones: assert property (
      reg_rd && reg_addr[0] && reg_addr <= LAST_IDX |=> reg_rdata[7:6] == 2'h3)
      else $error("mode bits 7:6 not read as one");
   a_ch12_buf_zero: assert property (
      reg_rd && (reg_addr == 4'h3 || reg_addr == 4'h5)
      |=> reg_rdata[5:4] == 2'h0) else $error("ch1/2 bits 5:4 not zero");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr > LAST_IDX |=> reg_rdata == 8'h00)
      else $error("unmapped index read not zero");
   a_bufd_no_event: assert property (
      (buffer_pair_b_enable & gr_d_events_enable) == 5'h00)
      else $error("register D events while buffering");
   a_bufc_no_event: assert property (
      (buffer_pair_a_enable & gr_c_events_enable) == 5'h00)
      else $error("register C events while buffering");
   a_ch12_no_bufa: assert property (buffer_pair_a_enable[2:1] == 2'h0)
      else $error("buffer A on channel 1 or 2");
   a_ph1_no_tick: assert property (s_ph1_held |-> !count_tick[1])
      else $error("channel 1 ticked in phase counting");
   a_ph2_no_tick: assert property (s_ph2_held |-> !count_tick[2])
      else $error("channel 2 ticked in phase counting");
   a_phase_ch12_only: assert property ((phase_mode & 5'h19) == 5'h00)
      else $error("phase mode on channel 0, 3 or 4");
   a_ch4_follows_ch3: assert property (
      eff_mode[3] inside {MD_RSYNC, MD_COMP1, MD_COMP2, MD_COMP3}
      |-> eff_mode[4] == eff_mode[3]) else $error("channel 4 not following");
   a_mode_wr_decode: assert property (s_mode0_wr |-> ##2
      eff_mode[0] == $past(reg_wdata[3:0], 2)
      && buffer_pair_b_enable[0] == $past(reg_wdata[5], 2))
      else $error("mode write not decoded after two cycles");
endmodule : tcm_clk_mode_sel_sva

bind tcm_clk_mode_sel tcm_clk_mode_sel_sva #(.PRESC_W(PRESC_W))
   u_tcm_clk_mode_sel_sva (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_tick(count_tick),
   .eff_mode(eff_mode), .phase_mode(phase_mode),
   .buffer_pair_a_enable(buffer_pair_a_enable),
   .buffer_pair_b_enable(buffer_pair_b_enable),
   .gr_c_events_enable(gr_c_events_enable),
   .gr_d_events_enable(gr_d_events_enable));

// ### test/tcm_clk_mode_sel_bench.sv
// Self-checking bench for the clock and mode selection block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   bad_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tcm_clk_mode_sel_bench
   import tcm_pkg::*;
;
   logic clk_sys;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic pin_a, pin_b, pin_c, pin_d, casc;
   logic [NUM_CH-1:0] count_tick, phase_mode, prohib, buf_a, buf_b;
   logic [NUM_CH-1:0] ev_c, ev_d;
   logic [NUM_CH-1:0][MD_W-1:0] eff_mode;
   int bad_count = 0;
   int total_checks = 0;
   // Expected ticks in 1024 cycles for each channel and select code.
   int exp_tab [5][8] = '{'{1024, 256, 0, 0, 128, 32, 8, 2},
      '{0, 256, 64, 16, 128, 32, 4, 512}, '{1024, 256, 0, 16, 128, 32, 8, 1},
      '{1024, 256, 64, 16, 4, 1, 128, 32},
      '{1024, 256, 64, 16, 4, 1, 128, 32}};
   int e_ch [6] = '{3, 3, 0, 0, 2, 1};
   logic [7:0] e_ctl [6] = '{8'h11, 8'h09, 8'h1c, 8'h0d, 8'h10, 8'h17};
   int e_exp [6] = '{512, 256, 256, 32, 1024, 512};

   tcm_clk_mode_sel #(.PRESC_W(PRE_W)) u_tcm_clk_mode_sel (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ext_clk_pin_a(pin_a), .ext_clk_pin_b(pin_b),
      .ext_clk_pin_c(pin_c), .ext_clk_pin_d(pin_d),
      .chan2_counter_ovf_unf(casc), .count_tick(count_tick),
      .eff_mode(eff_mode), .phase_mode(phase_mode),
      .mode_prohibited(prohib), .buffer_pair_a_enable(buf_a),
      .buffer_pair_b_enable(buf_b), .gr_c_events_enable(ev_c),
      .gr_d_events_enable(ev_d));
   tcm_pin_model u_tcm_pin_model (.clk_sys(clk_sys), .ext_clk_pin_a(pin_a),
      .ext_clk_pin_b(pin_b), .ext_clk_pin_c(pin_c), .ext_clk_pin_d(pin_d),
      .chan2_counter_ovf_unf(casc));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
   endtask : rdc

   task automatic count(input int ch, input int e);
      int n;
      n = 0;
      repeat (8) @(posedge clk_sys);
      repeat (1024) begin
         @(posedge clk_sys);
         #1;
         if (count_tick[ch] === 1'b1) n++;
      end
      `CHK("count_tick", e, n)
   endtask : count

   // Expected prohibited flag of a mode code on channels 0 to 3.
   function automatic int exp_pro(input int ch, input logic [3:0] c);
      if (c inside {4'h1, 4'h9, 4'ha, 4'hb, 4'hc}) return 1;
      if (c[3:2] == 2'b01) return (ch == 1 || ch == 2) ? 0 : 1;
      if (c == 4'h3) return (ch >= 3) ? 1 : 0;
      if (c[3]) return (ch == 3) ? 0 : 1;
      return 0;
   endfunction : exp_pro

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report

   initial begin
      #900000;
      bad_count++;
      final_report();
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         rdc(4'(2 * ch + 1), 8'hc0);
         rdc(4'(2 * ch), 8'h00);
      end
      `CHK("buf_a", 5'h00, buf_a)
      `CHK("ev_c", 5'h19, ev_c)
      `CHK("ev_d", 5'h19, ev_d)
      // software writes ones to bits 7 and 6
      for (int ch = 0; ch < NUM_CH; ch++) wr(4'(2 * ch + 1), 8'hfa);
      for (int ch = 0; ch < NUM_CH; ch++) begin
         rdc(4'(2 * ch + 1), (ch == 1 || ch == 2) ? 8'hca : 8'hfa);
      end
      wr(4'hc, 8'hff);
      rdc(4'hc, 8'h00);
      wr(4'h1, 8'hd0);
      repeat (3) @(posedge clk_sys);
      `CHK("buf_a", 5'h19, buf_a)
      `CHK("buf_b", 5'h18, buf_b)
      `CHK("ev_c", 5'h00, ev_c)
      `CHK("ev_d", 5'h01, ev_d)
      wr(4'h9, 8'hc0);
      for (int c = 0; c < 16; c++) begin
         for (int ch = 0; ch < 4; ch++) wr(4'(2 * ch + 1), {4'hc, 4'(c)});
         repeat (3) @(posedge clk_sys);
         for (int ch = 0; ch < 4; ch++) begin
            `CHK("eff_mode", 4'(c), eff_mode[ch])
            `CHK("phase", ch % 3 != 0 && c/4 == 1, phase_mode[ch])
            `CHK("prohib", exp_pro(ch, 4'(c)), prohib[ch])
         end
         `CHK("ch4_mode", (c == 8 || c > 12) ? c : 0, eff_mode[4])
         `CHK("prohib4", 0, prohib[4])
      end
      // modes are set before any count window opens
      for (int ch = 0; ch < NUM_CH; ch++) wr(4'(2 * ch + 1), 8'hc0);
      for (int ch = 0; ch < NUM_CH; ch++) begin
         for (int s = 0; s < 8; s++) begin
            wr(4'(2 * ch), 8'(s));
            count(ch, exp_tab[ch][s]);
         end
      end
      for (int i = 0; i < 6; i++) begin
         wr(4'(2 * e_ch[i]), e_ctl[i]);
         count(e_ch[i], e_exp[i]);
      end
      for (int ch = 1; ch < 3; ch++) begin
         wr(4'(2 * ch), 8'h01);
         wr(4'(2 * ch + 1), 8'hc4);
         count(ch, 0);
      end
      // A second reset in mid-run brings registers and enables back.
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(4'h3, 8'hc0);
      rdc(4'h2, 8'h00);
      `CHK("ev_c", 5'h19, ev_c)
      final_report();
   end
endmodule : tcm_clk_mode_sel_bench
